// ### rtl/mbg_pkg.sv
// Constants shared by the memory and I/O bus glue
package mbg_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int PROG_DEPTH = 65536;
   localparam int BLOCK_W = 3;
   localparam int BLOCK_OFF_W = 13;
   localparam int BLOCK_DEPTH = 8192;
   localparam int NUM_BLOCKS = 8;
   // Block numbers from the top three address bits
   localparam logic [2:0] BLK_NVM = 3'h0;
   localparam logic [2:0] BLK_RAM = 3'h1;
   localparam logic [2:0] BLK_IO = 3'h3;
   // Shared address of both discrete latches
   localparam logic [15:0] DISCRETE_INPUT_LATCH_ADDR = 16'h6000;
   localparam logic [15:0] AUDIO_ROUTE_OUTPUT_LATCH_ADDR = 16'h6000;
   localparam logic [7:0] AUDIO_ROUTE_RESET = 8'h00;
   localparam logic [7:0] ADDR_LO_RESET = 8'h00;
   // Input latch bit layout
   localparam int IN_DC_LSB = 0;
   localparam int IN_DC_W = 3;
   localparam int IN_BATT = 3;
   localparam int IN_REMOTE = 4;
   localparam int IN_TX_INHIBIT = 5;
   localparam int IN_TONE = 6;
   localparam int IN_STATUS = 7;
endpackage

// ### rtl/mbg_bus_glue.sv
// Address latch, decoder, memories and discrete latches behind the micro bus
// Behaviour
// [R1] Separate 64k program and data spaces
// [R2] Master holds fetch strobe low during fetch
// [R3] Fetch strobe low disables data decoder
// [R4] Low address byte latched while strobe high
// [R5] Program memory drives instruction during fetch
// [R6] RAM selected, read strobe: drive byte
// [R7] RAM selected, write strobe: store byte
// [R8] Nonvolatile enable blocked during reset
// [R9] Nonvolatile selected, read strobe: drive byte
// [R10] Nonvolatile selected, write strobe: store byte
// [R11] Both latches at 6000H, split by strobe
// [R12] Input latch read shows discrete inputs
// [R13] Battery flag high on battery power
// [R14] Output latch captures on falling write
// [R15] Output latch holds; reads leave it
// [R16] At most one select, only during strobe
// [R17] Top three bits pick 8k block
// [R18] Nonvolatile block0, RAM block1, latches block3
`timescale 1ns/100ps
module mbg_bus_glue (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Microcontroller bus
   input wire logic addr_strobe,
   input wire logic program_fetch_strobe_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [mbg_pkg::DATA_W-1:0] ad_in,
   output logic [mbg_pkg::DATA_W-1:0] ad_out,
   output logic ad_oe,
   input wire logic [mbg_pkg::DATA_W-1:0] addr_hi,
   // Program memory loading port
   input wire logic prog_load_en,
   input wire logic [mbg_pkg::ADDR_W-1:0] prog_load_addr,
   input wire logic [mbg_pkg::DATA_W-1:0] prog_load_data,
   // Data-space selects
   output logic [mbg_pkg::NUM_BLOCKS-1:0] block_sel_n,
   output logic nvm_ce_n,
   // Discrete inputs
   input wire logic [mbg_pkg::IN_DC_W-1:0] dc_control_decode,
   input wire logic battery_standby_flag,
   input wire logic remote_keying_request,
   input wire logic tx_inhibit,
   input wire logic tone_squelch_monitor,
   input wire logic station_status_input,
   // Audio switch selects
   output logic [mbg_pkg::DATA_W-1:0] audio_route
);
   import mbg_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Storage
   logic [DATA_W-1:0] prog_mem [PROG_DEPTH];
   logic [DATA_W-1:0] ram_mem [BLOCK_DEPTH];
   logic [DATA_W-1:0] nvm_mem [BLOCK_DEPTH];
   logic [DATA_W-1:0] addr_lo;
   logic wr_n_q;

   ////////////////////////////////////////////////////////////////////////
   // Address and decode
   wire logic [ADDR_W-1:0] full_addr;
   wire logic [BLOCK_W-1:0] block_num;
   wire logic [BLOCK_OFF_W-1:0] block_off;
   wire logic fetching;
   wire logic strobe_active;
   wire logic decode_en;
   wire logic ram_sel;
   wire logic nvm_sel;
   wire logic io_sel;
   wire logic wr_fall;
   wire logic [DATA_W-1:0] discrete_input_latch;
   logic [DATA_W-1:0] next_ad_out;
   logic next_ad_oe;

   assign full_addr = {addr_hi, addr_lo}; // R4 R5
   assign block_num = full_addr[ADDR_W-1 -: BLOCK_W]; // R17
   assign block_off = full_addr[BLOCK_OFF_W-1:0];
   assign fetching = !program_fetch_strobe_n; // R1
   assign strobe_active = !rd_n || !wr_n;
   // Fetch wins so the AD lines never see two drivers
   assign decode_en = !fetching && strobe_active; // R3 R16

   genvar gi;
   generate
      for (gi = 0; gi < NUM_BLOCKS; gi++) begin : g_sel
         assign block_sel_n[gi] = !(decode_en && (block_num == BLOCK_W'(gi))); // R17 R16
      end
   endgenerate

   // Supervisor gate: no stray nonvolatile writes while reset is held
   assign nvm_ce_n = block_sel_n[BLK_NVM] || rst; // R8 R18
   assign ram_sel = !block_sel_n[BLK_RAM]; // R18
   assign nvm_sel = !nvm_ce_n;
   assign io_sel = !block_sel_n[BLK_IO]; // R11 R18
   // Edge, not level: outside reset a strobe held low stores once
   assign wr_fall = wr_n_q && !wr_n;

   assign discrete_input_latch[IN_DC_LSB +: IN_DC_W] = dc_control_decode; // R12
   assign discrete_input_latch[IN_BATT] = battery_standby_flag; // R13
   assign discrete_input_latch[IN_REMOTE] = remote_keying_request;
   assign discrete_input_latch[IN_TX_INHIBIT] = tx_inhibit;
   assign discrete_input_latch[IN_TONE] = tone_squelch_monitor;
   assign discrete_input_latch[IN_STATUS] = station_status_input;

   ////////////////////////////////////////////////////////////////////////
   // Read data selection
   always_comb begin
      next_ad_out = ad_out;
      next_ad_oe = 1'b0;
      if (fetching) begin
         next_ad_out = prog_mem[full_addr]; // R5
         next_ad_oe = 1'b1;
      end else if (!rd_n) begin
         if (ram_sel) begin
            next_ad_out = ram_mem[block_off]; // R6
            next_ad_oe = 1'b1;
         end else if (nvm_sel) begin
            next_ad_out = nvm_mem[block_off]; // R9
            next_ad_oe = 1'b1;
         end else if (io_sel) begin
            next_ad_out = discrete_input_latch; // R11 R12
            next_ad_oe = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         addr_lo <= ADDR_LO_RESET;
         ad_out <= '0;
         ad_oe <= 1'b0;
         wr_n_q <= 1'b1;
         audio_route <= AUDIO_ROUTE_RESET;
      end else if (clk_en) begin
         if (addr_strobe) begin
            addr_lo <= ad_in; // R4
         end
         ad_out <= next_ad_out;
         ad_oe <= next_ad_oe;
         wr_n_q <= wr_n;
         // Besides reset, only a write edge loads it; reads never touch it
         if (wr_fall && io_sel) begin
            audio_route <= ad_in; // R14 R15 R11
         end
      end
   end

   // Memory arrays carry no reset, as the parts they stand for
   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         // Loader only; the master has no write path into program space
         if (prog_load_en) begin
            prog_mem[prog_load_addr] <= prog_load_data;
         end
         if (wr_fall && ram_sel) begin
            ram_mem[block_off] <= ad_in; // R7
         end
         if (wr_fall && nvm_sel) begin
            nvm_mem[block_off] <= ad_in; // R10
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_write_edge;
      clk_en && wr_n_q && !wr_n;
   endsequence

   sequence s_io_write;
      s_write_edge ##0 io_sel;
   endsequence

   sequence s_read_cycle;
      clk_en && !fetching && !rd_n;
   endsequence

   sequence s_io_read;
      s_read_cycle ##0 io_sel;
   endsequence

   a_fetch_no_sel: assert property (@(posedge sys_clk) disable iff (rst) // R3
      fetching |-> (&block_sel_n && nvm_ce_n))
      else $error("data select active during program fetch");

   a_single_sel: assert property (@(posedge sys_clk) disable iff (rst) // R16
      $onehot0(~block_sel_n) && (!(&block_sel_n) -> strobe_active))
      else $error("bad data select pattern");

   a_nvm_reset_gate: assert property (@(posedge sys_clk) // R8
      rst |-> nvm_ce_n)
      else $error("nonvolatile enable active in reset");

   a_addr_capture: assert property (@(posedge sys_clk) disable iff (rst) // R4
      (clk_en && addr_strobe) |=> (addr_lo == $past(ad_in)))
      else $error("low address byte not captured");

   a_fetch_drive: assert property (@(posedge sys_clk) disable iff (rst) // R5
      (clk_en && fetching) |=> (ad_oe && ad_out == $past(prog_mem[full_addr])))
      else $error("instruction not driven during fetch");

   a_ram_store: assert property (@(posedge sys_clk) disable iff (rst) // R7
      (s_write_edge ##0 ram_sel) |=> (ram_mem[$past(block_off)] == $past(ad_in)))
      else $error("RAM write lost");

   a_input_read: assert property (@(posedge sys_clk) disable iff (rst) // R12 R13
      (clk_en && !fetching && !rd_n && io_sel) |=>
         (ad_oe && ad_out == $past(discrete_input_latch) &&
          ad_out[IN_BATT] == $past(battery_standby_flag)))
      else $error("input latch read wrong");

   a_latch_capture: assert property (@(posedge sys_clk) disable iff (rst) // R14
      s_io_write |=> (audio_route == $past(ad_in)))
      else $error("output latch did not capture");

   a_latch_hold: assert property (@(posedge sys_clk) disable iff (rst) // R15
      !(clk_en && wr_n_q && !wr_n && io_sel) |=> $stable(audio_route))
      else $error("output latch changed without write");

   a_read_quiet: assert property (@(posedge sys_clk) disable iff (rst) // R6 R9
      (clk_en && rd_n && !fetching) |=> !ad_oe)
      else $error("bus driven with no read");

   ////////////////////////////////////////////////////////////////////////
   // Decode, map, memory and freeze checks
   a_ram_read: assert property (@(posedge sys_clk) disable iff (rst) // R6
      (s_read_cycle ##0 ram_sel) |=> (ad_oe && ad_out == $past(ram_mem[block_off])))
      else $error("RAM read wrong");

   a_nvm_read: assert property (@(posedge sys_clk) disable iff (rst) // R9
      (s_read_cycle ##0 nvm_sel) |=> (ad_oe && ad_out == $past(nvm_mem[block_off])))
      else $error("nonvolatile read wrong");

   a_oe_on_read: assert property (@(posedge sys_clk) disable iff (rst) // R6 R9
      (s_read_cycle ##0 (ram_sel || nvm_sel || io_sel)) |=> ad_oe)
      else $error("bus not driven on a mapped read");

   a_empty_read: assert property (@(posedge sys_clk) disable iff (rst) // R16
      (s_read_cycle ##0 !(ram_sel || nvm_sel || io_sel)) |=> !ad_oe)
      else $error("bus driven for an unmapped block");

   a_batt_level: assert property (@(posedge sys_clk) disable iff (rst) // R13
      (s_io_read ##0 battery_standby_flag) |=> ad_out[IN_BATT])
      else $error("battery flag read low");

   a_nvm_store: assert property (@(posedge sys_clk) disable iff (rst) // R10
      (s_write_edge ##0 nvm_sel) |=> (nvm_mem[$past(block_off)] == $past(ad_in)))
      else $error("nonvolatile write lost");

   a_held_write: assert property (@(posedge sys_clk) disable iff (rst) // R14
      (clk_en && !wr_n_q && !wr_n && io_sel) |=> $stable(audio_route))
      else $error("held write strobe loaded output latch again");

   a_read_no_latch: assert property (@(posedge sys_clk) disable iff (rst) // R15
      (s_io_read ##0 wr_n) |=> $stable(audio_route))
      else $error("read changed output latch");

   a_write_refused: assert property (@(posedge sys_clk) disable iff (rst) // R11
      (s_write_edge ##0 !io_sel) |=> $stable(audio_route))
      else $error("output latch loaded from another block");

   a_in_latch_addr: assert property (@(posedge sys_clk) disable iff (rst) // R11
      (!fetching && !rd_n && full_addr == DISCRETE_INPUT_LATCH_ADDR) |-> io_sel)
      else $error("input latch not selected at its address");

   a_out_latch_addr: assert property (@(posedge sys_clk) disable iff (rst) // R11
      (!fetching && !wr_n && full_addr == AUDIO_ROUTE_OUTPUT_LATCH_ADDR) |-> io_sel)
      else $error("output latch not selected at its address");

   a_block_decode: assert property (@(posedge sys_clk) disable iff (rst) // R17
      decode_en |-> ((~block_sel_n) == (8'h01 << block_num)))
      else $error("block select does not follow top address bits");

   a_block_map: assert property (@(posedge sys_clk) disable iff (rst) // R18
      decode_en |-> ((ram_sel == (block_num == BLK_RAM)) && (io_sel == (block_num == BLK_IO))
         && (nvm_sel == (block_num == BLK_NVM))))
      else $error("data block map wrong");

   a_sel_needs_strobe: assert property (@(posedge sys_clk) disable iff (rst) // R16
      (rd_n && wr_n) |-> &block_sel_n)
      else $error("data select active with no strobe");

   a_addr_hold: assert property (@(posedge sys_clk) disable iff (rst) // R4
      (clk_en && !addr_strobe) |=> $stable(addr_lo))
      else $error("low address byte changed without strobe");

   a_clk_freeze: assert property (@(posedge sys_clk) disable iff (rst) // R15
      !clk_en |=> ($stable(audio_route) && $stable(ad_out) && $stable(ad_oe) && $stable(addr_lo)))
      else $error("state moved while clock enable low");

   a_nvm_reset_write: assert property (@(posedge sys_clk) // R8
      (s_write_edge ##0 (rst && !block_sel_n[BLK_NVM])) |=>
         (nvm_mem[$past(block_off)] === $past(nvm_mem[block_off])))
      else $error("nonvolatile memory written in reset");

   a_nvm_gate_free: assert property (@(posedge sys_clk) // R8
      (!rst && !block_sel_n[BLK_NVM]) |-> !nvm_ce_n)
      else $error("nonvolatile enable blocked outside reset");

endmodule // mbg_bus_glue

// ### test/mbg_host_model.sv
// Bus master model for the multiplexed micro bus
`timescale 1ns/100ps
module mbg_host_model (
   // Clock
   input wire logic sys_clk,
   // Driven bus
   output logic addr_strobe,
   output logic program_fetch_strobe_n,
   output logic rd_n,
   output logic wr_n,
   output logic [7:0] ad_in,
   output logic [7:0] addr_hi,
   // Observed bus
   input wire logic [7:0] ad_out,
   input wire logic ad_oe,
   input wire logic [7:0] block_sel_n,
   input wire logic nvm_ce_n
);
   logic [7:0] q = 8'h00;
   logic [7:0] sel = 8'h00;
   logic oe = 1'b0;
   logic ce = 1'b0;
   initial begin
      {addr_strobe, program_fetch_strobe_n, rd_n, wr_n} = 4'h7;
      {ad_in, addr_hi} = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////
   // Kind 0 write, 1 read, 2 fetch
   task automatic cyc(input logic [3:0] kind, input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr_strobe <= 1'b1;
      {addr_hi, ad_in} <= a;
      @(posedge sys_clk);
      addr_strobe <= 1'b0;
      // Undriven lines flip so a stale byte never looks valid
      ad_in <= (kind == 4'h0) ? d : ~a[7:0];
      wr_n <= (kind != 4'h0);
      rd_n <= (kind != 4'h1);
      program_fetch_strobe_n <= (kind != 4'h2);
      @(posedge sys_clk);
      sel = block_sel_n;
      ce = nvm_ce_n;
      @(posedge sys_clk);
      // A released bus reads back as noise, never as the last byte
      q = ad_oe ? ad_out : ~ad_out;
      oe = ad_oe;
      {program_fetch_strobe_n, rd_n, wr_n} <= 3'h7;
      ad_in <= ~ad_in;
   endtask
endmodule // mbg_host_model

// ### test/test_memory_and_io_bus_glue.sv
// Self-checking bench for the memory and I/O bus glue
`timescale 1ns/100ps
module test_memory_and_io_bus_glue;
   import mbg_pkg::*;
   logic sys_clk, rst, clk_en, prog_load_en, addr_strobe, program_fetch_strobe_n, rd_n, wr_n;
   logic ad_oe, nvm_ce_n;
   logic [7:0] ad_in, ad_out, addr_hi, block_sel_n, audio_route, prog_load_data, disc;
   logic [15:0] prog_load_addr;
   logic [55:0] r;
   int bad_count = 0;
   int total_checks = 0;
   // Kind, address, data, read byte, drive enable, selects, audio route
   localparam logic [55:0] ROWS [10] = '{
      56'h0_0000_C3_00_0_FE_00, 56'h0_2005_3C_00_0_FD_00, 56'h0_6000_A5_00_0_F7_A5,
      56'h1_2005_00_3C_1_FD_A5, 56'h1_0000_00_C3_1_FE_A5, 56'h1_6000_00_AD_1_F7_A5,
      56'h1_4000_00_00_0_FB_A5, 56'h2_1234_00_7E_1_FF_A5, 56'h0_7FFF_5A_00_0_F7_5A,
      56'h0_6000_3C_00_0_F7_3C};
   mbg_bus_glue i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .addr_strobe(addr_strobe),
      .program_fetch_strobe_n(program_fetch_strobe_n), .rd_n(rd_n), .wr_n(wr_n),
      .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .addr_hi(addr_hi),
      .prog_load_en(prog_load_en), .prog_load_addr(prog_load_addr),
      .prog_load_data(prog_load_data), .block_sel_n(block_sel_n), .nvm_ce_n(nvm_ce_n),
      .dc_control_decode(disc[2:0]), .battery_standby_flag(disc[3]),
      .remote_keying_request(disc[4]), .tx_inhibit(disc[5]), .tone_squelch_monitor(disc[6]),
      .station_status_input(disc[7]), .audio_route(audio_route));
   mbg_host_model i_host (.sys_clk(sys_clk), .addr_strobe(addr_strobe),
      .program_fetch_strobe_n(program_fetch_strobe_n), .rd_n(rd_n), .wr_n(wr_n),
      .ad_in(ad_in), .addr_hi(addr_hi), .ad_out(ad_out), .ad_oe(ad_oe),
      .block_sel_n(block_sel_n), .nvm_ce_n(nvm_ce_n));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("Checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {clk_en, rst, prog_load_en, prog_load_addr, prog_load_data, disc} = {3'h7, 16'h1234, 16'h7EAD};
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      prog_load_en <= 1'b0;
      #1;
      chk("audio reset", audio_route, AUDIO_ROUTE_RESET);
      for (int i = 0; i < 10; i++) begin
         r = ROWS[i];
         i_host.cyc(r[55:52], r[51:36], r[35:28]);
         #1;
         if (r[19:16] == 4'h1) chk("read byte", i_host.q, r[27:20]);
         chk("drive enable", {7'h00, i_host.oe}, {4'h0, r[19:16]});
         chk("selects", i_host.sel, r[15:8]);
         chk("audio route", audio_route, r[7:0]);
      end
      // Inverse discrete pattern, then a latch write while the clock enable is low
      @(posedge sys_clk);
      disc <= 8'h52;
      i_host.cyc(4'h1, 16'h6000, 8'h00);
      chk("inverse inputs", i_host.q, 8'h52);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      i_host.cyc(4'h0, 16'h6000, 8'h99);
      chk("frozen latch", audio_route, 8'h3C);
      clk_en <= 1'b1;
      // Second reset; the low byte is cleared, so the stray write aims at offset 0
      @(posedge sys_clk);
      rst <= 1'b1;
      i_host.cyc(4'h0, 16'h0000, 8'h55);
      chk("nvm enable", {7'h00, i_host.ce}, 8'h01);
      chk("audio reset", audio_route, AUDIO_ROUTE_RESET);
      @(posedge sys_clk);
      rst <= 1'b0;
      i_host.cyc(4'h1, 16'h0000, 8'h00);
      chk("nvm kept", i_host.q, 8'hC3);
      print_verdict();
   end
endmodule // test_memory_and_io_bus_glue
